// [include/wdt_pkg.sv]
// Package holding register map, field positions and timing constants of the watchdog block.
`default_nettype none
package wdt_pkg;
  localparam logic [7:0] CTRL_ADDR      = 8'h60;
  localparam logic [7:0] CAUSE_ADDR     = 8'h54;
  localparam int         IRQ_FLAG_BIT   = 7;
  localparam int         IRQ_EN_BIT     = 6;
  localparam int         SEL3_BIT       = 5;
  localparam int         UNLOCK_BIT     = 4;
  localparam int         RST_EN_BIT     = 3;
  localparam int         TIMEOUT_CAUSE_BIT = 3;
  localparam int         SEL_LOW_MSB    = 2;
  localparam int         EXT_BIT        = 1;
  localparam int         POR_BIT        = 0;
  localparam logic [3:0] SEL_MAX        = 4'h9;
  localparam int         BASE_LOG2      = 11;
  localparam int         CNT_W          = 21;
  localparam logic [2:0] UNLOCK_CYCLES  = 3'h4;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] CAUSE_RESET    = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;
endpackage
`default_nettype wire

// [core/enhanced_watchdog_timer.sv]
// Watchdog timer with control register, reset cause flags and timed change unlock.
//
// Summary of operation
// - External reset sets flag; power-on or write-zero clears.
// - Power-on flag set by power-on, cleared by software.
// - Control register at 0x60 with documented bit layout.
// - Timeout in interrupt mode sets interrupt flag.
// - Flag clears on vector taken or write one.
// - Interrupt requested when global, enable and flag set.
// - Reset and interrupt enables select the four modes.
// - Vector in combined mode clears enable and flag.
// - Unserviced flag at next timeout causes reset in combined mode.
// - Programmed fuse forces system reset mode.
// - Clear reset enable or change length needs unlock.
// - Unlock bit clears itself four clocks later.
// - Reset enable held set while watchdog cause set.
// - Length select doubles from 2048 to 1048576 cycles.
// - Counter advances on slow oscillator ticks.
// - Restart clears counter to zero.
// - Unlock by writing unlock and reset enable together.
// - Timeout reset is one clock pulse, sets cause.
//
// Chosen here: strobed register access.
`default_nettype none
module enhanced_watchdog_timer (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       power_on_reset_in,
  input  wire logic       external_reset_in,
  input  wire logic       slow_osc_in,
  input  wire logic       always_on_fuse_in,
  input  wire logic       global_irq_enable_in,
  input  wire logic       vector_taken_in,
  input  wire logic       restart_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            irq_out,
  output logic            system_reset_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus request bundle and decode.
  wdt_pkg::bus_req_type req;
  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  wire ctrl_hit  = (req.addr == wdt_pkg::CTRL_ADDR);
  wire cause_hit = (req.addr == wdt_pkg::CAUSE_ADDR);
  wire ctrl_wr   = req.wr && ctrl_hit;
  wire cause_wr  = req.wr && cause_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins from outside the clock domain.
  logic [1:0] osc_sync_ff, por_sync_ff, ext_sync_ff, fuse_sync_ff;
  logic       osc_prev_ff;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      osc_sync_ff  <= 2'h0;
      por_sync_ff  <= 2'h0;
      ext_sync_ff  <= 2'h0;
      fuse_sync_ff <= 2'h3;
      osc_prev_ff  <= 1'b0;
    end else begin
      osc_sync_ff  <= {osc_sync_ff[0], slow_osc_in};
      por_sync_ff  <= {por_sync_ff[0], power_on_reset_in};
      ext_sync_ff  <= {ext_sync_ff[0], external_reset_in};
      fuse_sync_ff <= {fuse_sync_ff[0], always_on_fuse_in};
      osc_prev_ff  <= osc_sync_ff[1];
    end
  end
  // The slow oscillator is only sampled; a rising edge gives a one-cycle tick.
  wire osc_tick = osc_sync_ff[1] && !osc_prev_ff;
  wire por_evt  = por_sync_ff[1];
  wire ext_evt  = ext_sync_ff[1];
  wire fuse_on  = !fuse_sync_ff[1];                  // Programmed fuse reads zero.

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0]               cause_ff;
  logic                     irq_flag_ff, irq_en_ff, unlock_ff, rst_en_ff;
  logic [3:0]               sel_ff;
  logic [2:0]               unlock_cnt_ff;
  logic [wdt_pkg::CNT_W-1:0] count_ff;

  // The timeout cause flag overrides the stored enable, so a failing system keeps resetting.
  wire timeout_cause = cause_ff[wdt_pkg::TIMEOUT_CAUSE_BIT];
  wire rst_en_e = rst_en_ff || timeout_cause;        // Cause flag forces enable.
  wire mode_rst = fuse_on || rst_en_e;
  wire mode_irq = !fuse_on && irq_en_ff;
  wire running  = mode_rst || mode_irq;              // Both zero means stopped.

  // Timeout length from the current select, so shrinking it can expire at once.
  wire [4:0]                sel_shift = 5'(wdt_pkg::BASE_LOG2) + 5'(sel_ff);
  wire [wdt_pkg::CNT_W:0]   limit     = (wdt_pkg::CNT_W+1)'(1) << sel_shift;
  wire                      expire    = running && osc_tick &&
                                        ({1'b0, count_ff} + 1'b1 >= limit);
  // Combined mode: first timeout interrupts, a second with flag pending resets.
  wire to_irq   = expire && mode_irq;
  wire to_reset = expire && mode_rst && !(mode_irq && !irq_flag_ff);
  wire irq_take = irq_flag_ff && irq_en_ff && global_irq_enable_in;
  wire vect_clr = vector_taken_in && irq_flag_ff;

  // Unlocked writes may clear reset enable or change the select; locked ones only set.
  wire unlocked   = unlock_ff;
  wire [3:0] wsel = {req.wdata[wdt_pkg::SEL3_BIT], req.wdata[wdt_pkg::SEL_LOW_MSB:0]};
  wire sel_ok     = (wsel <= wdt_pkg::SEL_MAX);       // Reserved codes are refused.
  wire unlock_req = ctrl_wr && req.wdata[wdt_pkg::UNLOCK_BIT] && req.wdata[wdt_pkg::RST_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Control register update.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_flag_ff   <= 1'b0;
      irq_en_ff     <= 1'b0;
      unlock_ff     <= 1'b0;
      unlock_cnt_ff <= 3'h0;
      rst_en_ff     <= 1'b0;
      sel_ff        <= 4'h0;
    end else begin
      // Hardware set wins over any clear in the same cycle.
      if (to_irq)
        irq_flag_ff <= 1'b1;
      else if (vect_clr || (ctrl_wr && req.wdata[wdt_pkg::IRQ_FLAG_BIT]))
        irq_flag_ff <= 1'b0;
      if (vect_clr && rst_en_e)
        irq_en_ff <= 1'b0;
      else if (ctrl_wr)
        irq_en_ff <= req.wdata[wdt_pkg::IRQ_EN_BIT];
      // A clear is refused while the timeout cause is set; software must clear the cause first.
      if (ctrl_wr && (req.wdata[wdt_pkg::RST_EN_BIT] || (unlocked && !timeout_cause)))
        rst_en_ff <= req.wdata[wdt_pkg::RST_EN_BIT];
      if (ctrl_wr && unlocked && sel_ok)
        sel_ff <= wsel;
      if (unlock_req) begin
        unlock_ff     <= 1'b1;
        unlock_cnt_ff <= 3'h0;
      end else if (unlock_ff) begin
        unlock_cnt_ff <= unlock_cnt_ff + 3'h1;
        if (unlock_cnt_ff + 3'h1 >= wdt_pkg::UNLOCK_CYCLES || ctrl_wr)
          unlock_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter: restart, timeout and tick.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in)
      count_ff <= '0;
    else if (restart_in || expire || !running)
      count_ff <= '0;
    else if (osc_tick)
      count_ff <= count_ff + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause flags; the block reset clears all of them, power-on included.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cause_ff <= wdt_pkg::CAUSE_RESET;
    end else begin
      if (por_evt) begin
        cause_ff <= '0;
        cause_ff[wdt_pkg::POR_BIT] <= 1'b1;
      end else begin
        if (ext_evt)
          cause_ff[wdt_pkg::EXT_BIT] <= 1'b1;
        else if (cause_wr && !req.wdata[wdt_pkg::EXT_BIT])
          cause_ff[wdt_pkg::EXT_BIT] <= 1'b0;
        // A timeout in the same cycle as a software clear keeps the flag set.
        if (to_reset)
          cause_ff[wdt_pkg::TIMEOUT_CAUSE_BIT] <= 1'b1;
        else if (cause_wr && !req.wdata[wdt_pkg::TIMEOUT_CAUSE_BIT])
          cause_ff[wdt_pkg::TIMEOUT_CAUSE_BIT] <= 1'b0;
        if (cause_wr && !req.wdata[wdt_pkg::POR_BIT])
          cause_ff[wdt_pkg::POR_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and read data, all registered.
  wire [7:0] ctrl_view = {irq_flag_ff, irq_en_ff, sel_ff[3], unlock_ff,
                          rst_en_e, sel_ff[2:0]};
  wire [7:0] rd_mux    = ctrl_hit ? ctrl_view : (cause_hit ? cause_ff : 8'h00);
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out        <= 8'h00;
      irq_out          <= 1'b0;
      system_reset_out <= 1'b0;
    end else begin
      rdata_out        <= req.rd ? rd_mux : 8'h00;
      irq_out          <= irq_take;
      system_reset_out <= to_reset;                    // One clock long.
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_reset_pulse;
    @(posedge ref_clk_in) disable iff (reset_in) system_reset_out |=> !system_reset_out;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");
  property p_unlock_close;
    @(posedge ref_clk_in) disable iff (reset_in) $rose(unlock_ff) |-> ##[1:4] !unlock_ff;
  endproperty
  a_unlock_close: assert property (p_unlock_close) else $error("unlock held too long");
  property p_sel_locked;
    @(posedge ref_clk_in) disable iff (reset_in) !unlock_ff |=> $stable(sel_ff);
  endproperty
  a_sel_locked: assert property (p_sel_locked) else $error("select changed while locked");
  property p_cause_forces;
    @(posedge ref_clk_in) disable iff (reset_in) timeout_cause |-> ctrl_view[wdt_pkg::RST_EN_BIT];
  endproperty
  a_cause_forces: assert property (p_cause_forces) else $error("reset enable not forced");
  property p_irq_cause;
    @(posedge ref_clk_in) disable iff (reset_in) irq_out |-> $past(irq_flag_ff && irq_en_ff);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without flag and enable");
  property p_cause_set;
    @(posedge ref_clk_in) disable iff (reset_in) system_reset_out |-> timeout_cause;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause flag missing");
  property p_flag_set;
    @(posedge ref_clk_in) disable iff (reset_in) to_irq |=> irq_flag_ff;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on timeout");
  property p_restart;
    @(posedge ref_clk_in) disable iff (reset_in) restart_in |=> count_ff == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear");
  property p_fuse_mode;
    @(posedge ref_clk_in) disable iff (reset_in) fuse_on |-> !to_irq;
  endproperty
  a_fuse_mode: assert property (p_fuse_mode) else $error("interrupt under fuse");

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause flag checks.
  // These watch the synchronised events, which lag the raw pins by two flops.

  // An external reset event sets its flag unless power-on overrides it.
  property p_ext_set;
    @(posedge ref_clk_in) disable iff (reset_in) ext_evt && !por_evt |=> cause_ff[wdt_pkg::EXT_BIT];
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("external flag not set");

  // A power-on event wipes the external flag.
  property p_ext_por_clear;
    @(posedge ref_clk_in) disable iff (reset_in) por_evt |=> !cause_ff[wdt_pkg::EXT_BIT];
  endproperty
  a_ext_por_clear: assert property (p_ext_por_clear) else $error("external flag survived power-on");

  // A power-on event sets the power-on flag.
  property p_por_set;
    @(posedge ref_clk_in) disable iff (reset_in) por_evt |=> cause_ff[wdt_pkg::POR_BIT];
  endproperty
  a_por_set: assert property (p_por_set) else $error("power-on flag not set");

  // Outside the block reset, only a software write of zero takes the power-on flag away.
  property p_por_hold;
    @(posedge ref_clk_in) disable iff (reset_in)
      cause_ff[wdt_pkg::POR_BIT] && !(cause_wr && !req.wdata[wdt_pkg::POR_BIT]) |=> cause_ff[wdt_pkg::POR_BIT];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on flag lost");

  // A timeout in reset mode leaves its cause behind.
  property p_timeout_cause;
    @(posedge ref_clk_in) disable iff (reset_in) to_reset && !por_evt |=> timeout_cause;
  endproperty
  a_timeout_cause: assert property (p_timeout_cause) else $error("timeout cause not set");

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flag and enable checks.
  // A hardware set in the same cycle wins, so the clear checks exclude it.

  // Writing one to the flag clears it.
  property p_flag_w1c;
    @(posedge ref_clk_in) disable iff (reset_in)
      !to_irq && ctrl_wr && req.wdata[wdt_pkg::IRQ_FLAG_BIT] |=> !irq_flag_ff;
  endproperty
  a_flag_w1c: assert property (p_flag_w1c) else $error("flag not cleared by write");

  // Taking the vector clears the flag.
  property p_vector_clr;
    @(posedge ref_clk_in) disable iff (reset_in) vect_clr && !to_irq |=> !irq_flag_ff;
  endproperty
  a_vector_clr: assert property (p_vector_clr) else $error("flag not cleared by vector");

  // A pending, enabled and globally allowed flag raises the request.
  property p_irq_out;
    @(posedge ref_clk_in) disable iff (reset_in) irq_take |=> irq_out;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt request missing");

  // In combined mode the vector drops the enable, leaving reset mode.
  property p_comb_vector;
    @(posedge ref_clk_in) disable iff (reset_in) vect_clr && rst_en_e |=> !irq_en_ff;
  endproperty
  a_comb_vector: assert property (p_comb_vector) else $error("enable kept after vector");

  // In a reset mode, a timeout with the flag still pending resets the system.
  property p_second_timeout;
    @(posedge ref_clk_in) disable iff (reset_in) expire && mode_rst && irq_flag_ff |=> system_reset_out;
  endproperty
  a_second_timeout: assert property (p_second_timeout) else $error("unserviced timeout did not reset");

  ////////////////////////////////////////////////////////////////////////////
  // Protection and counter checks.

  // A locked write may not clear the reset enable.
  property p_rst_en_locked;
    @(posedge ref_clk_in) disable iff (reset_in)
      ctrl_wr && !unlocked && !req.wdata[wdt_pkg::RST_EN_BIT] |=> rst_en_ff == $past(rst_en_ff);
  endproperty
  a_rst_en_locked: assert property (p_rst_en_locked) else $error("reset enable cleared while locked");

  // The unlock write opens the window on the next edge.
  property p_unlock_set;
    @(posedge ref_clk_in) disable iff (reset_in) unlock_req |=> unlock_ff;
  endproperty
  a_unlock_set: assert property (p_unlock_set) else $error("unlock not opened");

  // Reserved select codes never reach the register.
  property p_sel_range;
    @(posedge ref_clk_in) disable iff (reset_in) sel_ff <= wdt_pkg::SEL_MAX;
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("reserved select stored");

  // A stopped timer holds its counter at zero.
  property p_stopped;
    @(posedge ref_clk_in) disable iff (reset_in) !running |=> count_ff == '0;
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer counted");

  // Each slow tick advances the counter by one unless something clears it.
  property p_count_step;
    @(posedge ref_clk_in) disable iff (reset_in)
      running && osc_tick && !expire && !restart_in |=> count_ff == $past(count_ff) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  // A timeout starts the next period from zero.
  property p_expire_clear;
    @(posedge ref_clk_in) disable iff (reset_in) expire |=> count_ff == '0;
  endproperty
  a_expire_clear: assert property (p_expire_clear) else $error("counter kept after timeout");

endmodule // enhanced_watchdog_timer
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench driving the watchdog block through its register port and event pins.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk_in = 1'b0, reset_in = 1'b1, power_on_reset_in = 1'b0, external_reset_in = 1'b0;
  logic       slow_osc_in = 1'b0, always_on_fuse_in = 1'b1, global_irq_enable_in = 1'b1;
  logic       vector_taken_in = 1'b0, restart_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, seen;
  logic       irq_out, system_reset_out;
  logic [1:0] div_ff = 2'h0;
  int         errors = 0, check_count = 0, rst_hi = 0;
  enhanced_watchdog_timer u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .power_on_reset_in(power_on_reset_in), .external_reset_in(external_reset_in), .slow_osc_in(slow_osc_in),
    .always_on_fuse_in(always_on_fuse_in), .global_irq_enable_in(global_irq_enable_in),
    .vector_taken_in(vector_taken_in), .restart_in(restart_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .system_reset_out(system_reset_out));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, slow oscillator at a quarter of the clock rate, and a count of reset pulse cycles.
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    div_ff <= div_ff + 2'h1;
    if (div_ff[0]) slow_osc_in <= ~slow_osc_in;
    if (system_reset_out === 1'b1) rst_hi++; // Each reset time-out must add exactly one high cycle.
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers for bus cycles, pin pulses and comparisons.
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in); wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
    @(posedge ref_clk_in); wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in); rd_in <= 1'b1; addr_in <= a;
    @(posedge ref_clk_in); rd_in <= 1'b0;
    #1 seen = rdata_out; // Read data stand only in the cycle after the strobe.
  endtask
  localparam int PIN_POR = 0, PIN_EXT = 1, PIN_VEC = 2, PIN_RST = 3;
  task automatic pin(input int which, input logic v);
    case (which)
      PIN_POR: power_on_reset_in <= v;
      PIN_EXT: external_reset_in <= v;
      PIN_VEC: vector_taken_in <= v;
      default: restart_in <= v;
    endcase
  endtask
  task automatic pulse(input int which, input int n);
    @(posedge ref_clk_in); pin(which, 1'b1);
    repeat (n) @(posedge ref_clk_in);
    pin(which, 1'b0);
    repeat (6) @(posedge ref_clk_in); // Pins pass through synchronisers first.
  endtask
  // Waits for the interrupt (sel 0) or a reset pulse (sel 1) and checks the span for 2048 ticks of 4 cycles.
  task automatic wait_ev(input bit sel);
    int n, r0;
    r0 = rst_hi;
    pulse(PIN_RST, 1);
    for (n = 6; n < 8400; n++) begin
      @(posedge ref_clk_in); #1;
      if (sel ? (rst_hi != r0) : (irq_out === 1'b1)) break;
    end
    check("timeout_span", {7'h0, n >= 8150 && n <= 8260}, 8'h01);
    check("reset_cycles", 8'(rst_hi - r0), {7'h0, sel});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset_values;
    rd(8'h60); check("ctrl", seen, 8'h00);
    rd(8'h54); check("cause", seen, 8'h00);
    rd(8'h61); check("unmapped", seen, 8'h00);
    $display("test reset_values done");
  endtask
  task automatic t_cause_flags;
    pulse(PIN_POR, 4); rd(8'h54); check("cause_por", seen, 8'h01);
    pulse(PIN_EXT, 4); rd(8'h54); check("cause_ext", seen, 8'h03);
    wr(8'h54, 8'h01); rd(8'h54); check("cause_clr_ext", seen, 8'h01);
    pulse(PIN_EXT, 4); pulse(PIN_POR, 4);
    rd(8'h54); check("cause_por_clears_ext", seen, 8'h01);
    wr(8'h54, 8'h00); rd(8'h54); check("cause_clr_por", seen, 8'h00);
    $display("test cause_flags done");
  endtask
  task automatic t_irq_mode;
    wr(8'h60, 8'h40); wait_ev(1'b0);
    rd(8'h60); check("irq_flag", seen, 8'hC0);
    @(posedge ref_clk_in);
    global_irq_enable_in <= 1'b0; repeat (2) @(posedge ref_clk_in); #1;
    check("irq_masked", {7'h0, irq_out}, 8'h00);
    @(posedge ref_clk_in);
    global_irq_enable_in <= 1'b1; repeat (2) @(posedge ref_clk_in); #1;
    check("irq_pending", {7'h0, irq_out}, 8'h01);
    wr(8'h60, 8'hC0); rd(8'h60); check("irq_flag_w1c", seen, 8'h40);
    $display("test irq_mode done");
  endtask
  task automatic t_combined;
    wr(8'h60, 8'h48); wait_ev(1'b0);
    rd(8'h60); check("comb_first", seen, 8'hC8);
    pulse(PIN_VEC, 1); rd(8'h60); check("comb_vector", seen, 8'h08);
    wait_ev(1'b1); rd(8'h54); check("cause_wdt", seen, 8'h08);
    wr(8'h60, 8'h18); wr(8'h60, 8'h00); rd(8'h60); check("rst_en_held", seen, 8'h08);
    wr(8'h54, 8'h00); pulse(PIN_RST, 1);
    wr(8'h60, 8'h01); rd(8'h60); check("locked_sel", seen, 8'h08);
    wr(8'h60, 8'h18); repeat (5) @(posedge ref_clk_in);
    wr(8'h60, 8'h01); rd(8'h60); check("unlock_expired", seen, 8'h08);
    wr(8'h60, 8'h18); wr(8'h60, 8'h2A); rd(8'h60); check("reserved_sel", seen, 8'h08);
    wr(8'h60, 8'h18); wr(8'h60, 8'h00); rd(8'h60); check("unlock_clear", seen, 8'h00);
    $display("test combined done");
  endtask
  task automatic t_fuse;
    @(posedge ref_clk_in);
    always_on_fuse_in <= 1'b0;
    wait_ev(1'b1); check("fuse_no_irq", {7'h0, irq_out}, 8'h00);
    rd(8'h54); check("fuse_cause", seen, 8'h08);
    @(posedge ref_clk_in);
    always_on_fuse_in <= 1'b1; wr(8'h54, 8'h00); pulse(PIN_RST, 1);
    $display("test fuse done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog against a hang.
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    t_reset_values(); t_cause_flags(); t_irq_mode(); t_combined(); t_fuse();
    conclude();
  end
  initial begin
    #600_000; // About 60000 cycles: the run needs under 40000.
    errors++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
